//--- spf_pkg.sv
// shared constants and types for the serial packet framer host
package spf_pkg;
   // ------------------------------------------------------------
   // framing characters
   // ------------------------------------------------------------
   localparam logic [7:0] ESCAPE_CHAR = 8'h80;
   localparam logic [7:0] FRAME_START_CHAR = 8'h81;
   localparam logic [7:0] FRAME_END_CHAR = 8'h82;
   localparam logic [7:0] ESC_CLEAR_MASK = 8'h7F;
   localparam logic [7:0] ESC_SET_MASK = 8'h80;
   // ------------------------------------------------------------
   // packet layout
   // ------------------------------------------------------------
   localparam int HDR_NODE_LSB = 0;
   localparam int HDR_TYPE_LSB = 4;
   localparam int HDR_RSV_BIT = 7;
   localparam logic [2:0] INFO_PACKET_SEQ_ZERO = 3'h0;
   localparam logic [2:0] INFO_PACKET_SEQ_ONE = 3'h1;
   localparam logic [2:0] LINK_RESET_PACKET = 3'h2;
   localparam logic [2:0] UNNUMBERED_ACK_PACKET = 3'h3;
   localparam logic [6:0] MAX_DATA = 7'h40;
   localparam logic [6:0] OVERHEAD = 7'h03;
   localparam logic [6:0] MAX_PKT = 7'h43;
   // ------------------------------------------------------------
   // crc: x^16 + x^12 + x^5 + 1, bit-reversed form, lsb first
   // ------------------------------------------------------------
   localparam logic [15:0] CRC_POLY_REV = 16'h8408;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int BAUD_BPS = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic rsv;
      logic [2:0] ptype;
      logic [3:0] node;
   } spf_hdr_s;
endpackage

//--- spf_uart.sv
// 8n1 uart at a fixed bit time, with a three-stage filtered receiver
`timescale 1ns/1ps
module spf_uart
   import spf_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic txd,
   input wire logic rxd,
   output logic rx_valid,
   output logic [7:0] rx_data
);
   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   logic [9:0] tsh_q;
   logic [3:0] tbits_q;
   logic [15:0] tcnt_q;
   wire tx_fire = tx_valid && tx_ready;
   wire tcnt_end = (tcnt_q == 16'(BIT_CYC - 1));

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tsh_q <= 10'h3FF;
         tbits_q <= 4'h0;
         tcnt_q <= 16'h0000;
         tx_ready <= 1'b0;
         txd <= 1'b1;
      end else if (tx_fire) begin
         tsh_q <= {1'b1, tx_data, 1'b0};
         tbits_q <= 4'hA;
         tcnt_q <= 16'h0000;
         tx_ready <= 1'b0;
      end else if (tbits_q != 4'h0) begin
         txd <= tsh_q[0];
         tcnt_q <= tcnt_end ? 16'h0000 : tcnt_q + 16'h0001;
         if (tcnt_end) begin
            tsh_q <= {1'b1, tsh_q[9:1]};
            tbits_q <= tbits_q - 4'h1;
            tx_ready <= (tbits_q == 4'h1);
         end
      end else begin
         txd <= 1'b1;
         tx_ready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   logic [SYNC_STAGES-1:0] sync_q;
   logic rx_lvl_q;
   logic rbusy_q;
   logic [3:0] rbits_q;
   logic [15:0] rcnt_q;
   logic [8:0] rsh_q;
   wire rcnt_end = (rcnt_q == 16'h0000);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync_q <= '1;
         rx_lvl_q <= 1'b1;
      end else begin
         sync_q <= {sync_q[SYNC_STAGES-2:0], rxd};
         if (sync_q[1] == sync_q[2]) begin
            rx_lvl_q <= sync_q[2];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rbusy_q <= 1'b0;
         rbits_q <= 4'h0;
         rcnt_q <= 16'h0000;
         rsh_q <= 9'h000;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         rx_valid <= 1'b0;
         if (!rbusy_q) begin
            if (!rx_lvl_q) begin
               rbusy_q <= 1'b1;
               rbits_q <= 4'hA;
               rcnt_q <= 16'(BIT_CYC / 2);
            end
         end else if (!rcnt_end) begin
            rcnt_q <= rcnt_q - 16'h0001;
         end else begin
            rcnt_q <= 16'(BIT_CYC - 1);
            rbits_q <= rbits_q - 4'h1;
            rsh_q <= {rx_lvl_q, rsh_q[8:1]};
            if (rbits_q == 4'hA && rx_lvl_q) begin
               rbusy_q <= 1'b0;
            end
            if (rbits_q == 4'h1) begin
               rbusy_q <= 1'b0;
               rx_valid <= rx_lvl_q;
               rx_data <= rsh_q[8:1];
            end
         end
      end
   end
endmodule // spf_uart

//--- spf_host.sv
// host end of the framed serial link: frame encoder, decoder and crc
// ------------------------------------------------------------
// How it works
// - characters travel full duplex, asynchronous, at 9600 bit/s
// - packets are 8-bit bytes, sent as frames of 8-bit characters
// - every frame opens with 0x81 and closes with 0x82
// - bytes 0x80..0x82 go as 0x80 then the byte with msb cleared
// - every other byte goes unchanged as one character
// - packet is one header byte, zero or more data, two crc bytes
// - header: node in bits 0-3, type in bits 4-6, bit 7 zero
// - type 0 is info packet sequence zero, type 1 sequence one
// - only the master sends type 2, the link reset packet
// - data section holds 0 to 64 bytes
// - crc bytes are chosen so crc over the whole packet is zero
// - crc polynomial is x^16 + x^12 + x^5 + 1
// - one master, many slaves, slave chosen by header address
// - packets whose whole-packet crc is not zero are dropped
// ------------------------------------------------------------
`timescale 1ns/1ps
module spf_host
   import spf_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic srst,
   output logic ser_txd,
   input wire logic ser_rxd,
   input wire logic tx_wr_en,
   input wire logic [5:0] tx_wr_addr,
   input wire logic [7:0] tx_wr_data,
   input wire logic tx_go,
   input wire logic [2:0] tx_type,
   input wire logic [3:0] tx_node,
   input wire logic [6:0] tx_len,
   output logic tx_busy,
   input wire logic [5:0] rx_rd_addr,
   output logic [7:0] rx_rd_data,
   output logic rx_pkt_valid,
   output spf_hdr_s rx_pkt_hdr,
   output logic [6:0] rx_pkt_len,
   output logic rx_pkt_drop
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic is_special(input logic [7:0] b);
      return (b == ESCAPE_CHAR) || (b == FRAME_START_CHAR) || (b == FRAME_END_CHAR);
   endfunction

   // ------------------------------------------------------------
   // uart
   // ------------------------------------------------------------
   logic u_tx_valid;
   logic [7:0] u_tx_data;
   logic u_tx_ready;
   logic u_rx_valid;
   logic [7:0] u_rx_data;

   spf_uart #(.BIT_CYC(BIT_CYC)) u_uart (
      .core_clk(core_clk),
      .srst(srst),
      .tx_valid(u_tx_valid),
      .tx_data(u_tx_data),
      .tx_ready(u_tx_ready),
      .txd(ser_txd),
      .rxd(ser_rxd),
      .rx_valid(u_rx_valid),
      .rx_data(u_rx_data)
   );

   // ------------------------------------------------------------
   // frame encoder
   // ------------------------------------------------------------
   typedef enum logic [2:0] {T_IDLE, T_SOM, T_BODY, T_ESC2, T_EOM} spf_tx_e;
   spf_tx_e tst_q;
   logic [7:0] tbuf [0:63];
   spf_hdr_s thdr_q;
   logic [6:0] tlen_q;
   logic [6:0] tidx_q;
   logic [15:0] tcrc_q;
   logic [3:0] exp_node_q;

   wire [6:0] tdat_idx = tidx_q - 7'h01;
   wire [7:0] cur_byte = (tidx_q == 7'h00) ? thdr_q :
                         (tidx_q <= tlen_q) ? tbuf[tdat_idx[5:0]] :
                         (tidx_q == tlen_q + 7'h01) ? tcrc_q[7:0] : tcrc_q[15:8];
   wire cur_special = is_special(cur_byte);
   wire tx_fire = u_tx_valid && u_tx_ready;
   wire last_body = (tidx_q == tlen_q + 7'h02);
   wire advance = tx_fire && ((tst_q == T_ESC2) || (tst_q == T_BODY && !cur_special));

   assign u_tx_valid = (tst_q != T_IDLE);
   assign u_tx_data = (tst_q == T_SOM) ? FRAME_START_CHAR :
                      (tst_q == T_EOM) ? FRAME_END_CHAR :
                      (tst_q == T_ESC2) ? (cur_byte & ESC_CLEAR_MASK) :
                      cur_special ? ESCAPE_CHAR : cur_byte;

   always_ff @(posedge core_clk) begin
      if (tx_wr_en && tst_q == T_IDLE) begin
         tbuf[tx_wr_addr] <= tx_wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tst_q <= T_IDLE;
         thdr_q <= '0;
         tlen_q <= 7'h00;
         tidx_q <= 7'h00;
         tcrc_q <= CRC_INIT;
         exp_node_q <= 4'h0;
         tx_busy <= 1'b0;
      end else begin
         unique case (tst_q)
            T_IDLE: begin
               if (tx_go) begin
                  thdr_q <= '{rsv: 1'b0, ptype: tx_type, node: tx_node};
                  exp_node_q <= tx_node;
                  tlen_q <= (tx_len > MAX_DATA) ? MAX_DATA : tx_len;
                  tidx_q <= 7'h00;
                  tcrc_q <= CRC_INIT;
                  tst_q <= T_SOM;
                  tx_busy <= 1'b1;
               end
            end
            T_SOM: if (tx_fire) tst_q <= T_BODY;
            T_BODY, T_ESC2: begin
               if (tx_fire && tst_q == T_BODY && cur_special) begin
                  tst_q <= T_ESC2;
               end else if (advance) begin
                  tst_q <= last_body ? T_EOM : T_BODY;
                  tidx_q <= tidx_q + 7'h01;
                  if (tidx_q <= tlen_q) begin
                     tcrc_q <= crc_byte(tcrc_q, cur_byte);
                  end
               end
            end
            T_EOM: begin
               if (tx_fire) begin
                  tst_q <= T_IDLE;
                  tx_busy <= 1'b0;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // frame decoder
   // ------------------------------------------------------------
   logic [7:0] rbuf [0:66];
   logic in_frame_q;
   logic esc_q;
   logic ovf_q;
   logic [6:0] rcnt_q;
   logic [15:0] rcrc_q;

   wire c_som = u_rx_valid && (u_rx_data == FRAME_START_CHAR);
   wire c_eom = u_rx_valid && in_frame_q && (u_rx_data == FRAME_END_CHAR);
   wire c_esc = u_rx_valid && in_frame_q && !c_eom && !esc_q && (u_rx_data == ESCAPE_CHAR);
   wire c_dat = u_rx_valid && in_frame_q && !c_som && !c_eom && !c_esc;
   wire [7:0] rbyte = esc_q ? (u_rx_data | ESC_SET_MASK) : u_rx_data;
   wire spf_hdr_s rhdr = rbuf[0];
   wire pkt_good = !ovf_q && (rcnt_q >= OVERHEAD) && (rcrc_q == 16'h0000)
                   && (rhdr.node == exp_node_q);
   wire [6:0] rd_idx = {1'b0, rx_rd_addr} + 7'h01;

   always_ff @(posedge core_clk) begin
      if (c_dat && rcnt_q < MAX_PKT) begin
         rbuf[rcnt_q] <= rbyte;
      end
      rx_rd_data <= rbuf[rd_idx];
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         in_frame_q <= 1'b0;
         esc_q <= 1'b0;
         ovf_q <= 1'b0;
         rcnt_q <= 7'h00;
         rcrc_q <= CRC_INIT;
         rx_pkt_valid <= 1'b0;
         rx_pkt_drop <= 1'b0;
         rx_pkt_hdr <= '0;
         rx_pkt_len <= 7'h00;
      end else begin
         rx_pkt_valid <= 1'b0;
         rx_pkt_drop <= 1'b0;
         if (c_som) begin
            in_frame_q <= 1'b1;
            esc_q <= 1'b0;
            ovf_q <= 1'b0;
            rcnt_q <= 7'h00;
            rcrc_q <= CRC_INIT;
         end else if (c_eom) begin
            in_frame_q <= 1'b0;
            rx_pkt_valid <= pkt_good;
            rx_pkt_drop <= !pkt_good;
            if (pkt_good) begin
               rx_pkt_hdr <= rhdr;
               rx_pkt_len <= rcnt_q - OVERHEAD;
            end
         end else if (c_esc) begin
            esc_q <= 1'b1;
         end else if (c_dat) begin
            esc_q <= 1'b0;
            rcrc_q <= crc_byte(rcrc_q, rbyte);
            if (rcnt_q < MAX_PKT) begin
               rcnt_q <= rcnt_q + 7'h01;
            end else begin
               ovf_q <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   a_first_char_som: assert property ((tst_q == T_SOM) |-> (u_tx_data == FRAME_START_CHAR))
      else $error("frame did not open with start char");
   a_last_char_eom: assert property (($past(tst_q) == T_EOM && tst_q == T_IDLE)
      |-> $past(u_tx_data) == FRAME_END_CHAR && $past(tx_fire))
      else $error("frame did not close with end char");
   a_escape_pair: assert property ((tx_fire && tst_q == T_BODY && cur_special)
      |=> tst_q == T_ESC2 && u_tx_data == ($past(cur_byte) & ESC_CLEAR_MASK))
      else $error("escape not followed by cleared byte");
   a_plain_byte: assert property ((tst_q == T_BODY && !cur_special) |-> u_tx_data == cur_byte)
      else $error("plain byte altered");
   a_hdr_rsv_zero: assert property ((tst_q != T_IDLE) |-> !thdr_q.rsv)
      else $error("header bit 7 not zero");
   a_len_limit: assert property (tlen_q <= MAX_DATA)
      else $error("data length above limit");
   a_crc_closes: assert property ((tst_q == T_EOM)
      |-> crc_byte(crc_byte(tcrc_q, tcrc_q[7:0]), tcrc_q[15:8]) == 16'h0000)
      else $error("sent crc does not close to zero");
   a_drop_bad_crc: assert property ((c_eom && rcrc_q != 16'h0000) |=> rx_pkt_drop && !rx_pkt_valid)
      else $error("bad crc packet delivered");
   a_som_restarts: assert property (c_som |=> in_frame_q && rcnt_q == 7'h00 && !esc_q)
      else $error("start char did not restart frame");
   a_unescape_msb: assert property ((c_dat && esc_q) |-> rbyte[7])
      else $error("escaped byte msb not restored");
   a_txd_idle: assert property ((tst_q == T_IDLE && $past(tst_q) == T_IDLE && u_tx_ready)
      |-> ser_txd)
      else $error("line not idle high");

   c_good_pkt: cover property (rx_pkt_valid);
   c_drop_pkt: cover property (rx_pkt_drop);
   c_escape_sent: cover property (tst_q == T_ESC2 && tx_fire);
   c_reset_pkt: cover property (tx_go && !tx_busy && tx_type == LINK_RESET_PACKET);
endmodule // spf_host

//--- spf_dev_model.sv
// behavioural slave device on the far side of the framed serial link
`timescale 1ns/1ps
module spf_dev_model
   import spf_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES,
   parameter logic [3:0] MY_NODE = 4'h1
) (
   input wire logic core_clk,
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] raw[$];
   logic [7:0] pkt[$];
   // ------------------------------------------------------------
   // character level, 8n1
   // ------------------------------------------------------------
   initial line_out = 1'b1;
   task automatic put_char(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
   endtask
   task automatic get_char(output logic [7:0] c);
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge core_clk);
         c[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge core_clk);
   endtask
   // ------------------------------------------------------------
   // packet level
   // ------------------------------------------------------------
   function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
      logic [15:0] r;
      r = CRC_INIT;
      foreach (b[i]) begin
         r = r ^ {8'h00, b[i]};
         repeat (8) r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
      end
      return r;
   endfunction
   task automatic put_pkt(input logic [7:0] b[$], input logic bad);
      logic [15:0] r;
      r = crc_of(b) ^ {15'h0000, bad};
      b.push_back(r[7:0]);
      b.push_back(r[15:8]);
      put_char(FRAME_START_CHAR);
      foreach (b[i]) begin
         if (b[i] inside {ESCAPE_CHAR, FRAME_START_CHAR, FRAME_END_CHAR}) begin
            put_char(ESCAPE_CHAR);
            put_char(b[i] & ESC_CLEAR_MASK);
         end else begin
            put_char(b[i]);
         end
      end
      put_char(FRAME_END_CHAR);
   endtask
   task automatic answer();
      logic [7:0] rep[$];
      repeat (3 * BIT_CYC) @(posedge core_clk);
      rep = pkt[0:$-2];
      if (pkt[0][6:4] == LINK_RESET_PACKET) begin
         rep.delete();
         rep.push_back({1'b0, UNNUMBERED_ACK_PACKET, MY_NODE});
      end
      if (pkt[0][6:4] != UNNUMBERED_ACK_PACKET) put_pkt(rep, 1'b0);
   endtask
   // ------------------------------------------------------------
   // frame receiver
   // ------------------------------------------------------------
   initial begin : rx_loop
      logic [7:0] c;
      logic in_fr;
      logic escape_char;
      in_fr = 1'b0;
      escape_char = 1'b0;
      forever begin
         get_char(c);
         // log the char before any reply goes out
         if (c == FRAME_START_CHAR) raw.delete();
         raw.push_back(c);
         if (c == FRAME_START_CHAR) begin
            pkt.delete();
            in_fr = 1'b1;
            escape_char = 1'b0;
         end else if (in_fr && c == FRAME_END_CHAR) begin
            in_fr = 1'b0;
            if (pkt.size() inside {[3:67]} && pkt[0][3:0] == MY_NODE && crc_of(pkt) == 16'h0000)
               answer();
         end else if (in_fr && c == ESCAPE_CHAR) begin
            escape_char = 1'b1;
         end else if (in_fr) begin
            pkt.push_back(escape_char ? (c | ESC_SET_MASK) : c);
            escape_char = 1'b0;
         end
      end
   end
endmodule // spf_dev_model

//--- serial_packet_framer_tb.sv
// self-checking bench for the host end of the framed serial link
`timescale 1ns/1ps
module serial_packet_framer_tb
   import spf_pkg::*;
;
   localparam int BC = 16;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic tx_wr_en = 1'b0;
   logic [5:0] tx_wr_addr = 6'h00;
   logic [7:0] tx_wr_data = 8'h00;
   logic tx_go = 1'b0;
   logic [2:0] tx_type = 3'h0;
   logic [3:0] tx_node = 4'h0;
   logic [6:0] tx_len = 7'h00;
   logic [5:0] rx_rd_addr = 6'h00;
   logic ser_txd, ser_rxd, tx_busy, rx_pkt_valid, rx_pkt_drop, got_v, got_d;
   logic [7:0] rx_rd_data;
   logic [6:0] rx_pkt_len;
   spf_hdr_s rx_pkt_hdr;
   int err_total = 0;
   int check_count = 0;

   spf_host #(.BIT_CYC(BC)) spf_host_inst (.core_clk(core_clk), .srst(srst), .ser_txd(ser_txd),
      .ser_rxd(ser_rxd), .tx_wr_en(tx_wr_en), .tx_wr_addr(tx_wr_addr), .tx_wr_data(tx_wr_data),
      .tx_go(tx_go), .tx_type(tx_type), .tx_node(tx_node), .tx_len(tx_len), .tx_busy(tx_busy),
      .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data), .rx_pkt_valid(rx_pkt_valid),
      .rx_pkt_hdr(rx_pkt_hdr), .rx_pkt_len(rx_pkt_len), .rx_pkt_drop(rx_pkt_drop));
   spf_dev_model #(.BIT_CYC(BC), .MY_NODE(4'h1)) spf_dev_model_inst (.core_clk(core_clk),
      .line_in(ser_txd), .line_out(ser_rxd));

   initial forever #2.5 core_clk = ~core_clk;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (err_total == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic host_send(input logic [2:0] ty, input logic [6:0] ln, input logic [7:0] d[$]);
      int n;
      foreach (d[i]) begin
         @(negedge core_clk);
         tx_wr_en = 1'b1;
         tx_wr_addr = 6'(i);
         tx_wr_data = d[i];
      end
      @(negedge core_clk);
      tx_wr_en = 1'b0;
      {tx_type, tx_node, tx_len, tx_go} = {ty, 4'h1, ln, 1'b1};
      @(negedge core_clk);
      tx_go = 1'b0;
      for (n = 0; n < 30000 && tx_busy !== 1'b0; n++) @(negedge core_clk);
      check({15'h0000, tx_busy}, 16'h0000);
   endtask
   task automatic expect_rx(input logic v, input logic [7:0] h, input logic [6:0] l);
      got_v = 1'b0;
      got_d = 1'b0;
      for (int n = 0; n < 30000 && !got_v && !got_d; n++) begin
         @(negedge core_clk);
         got_v = (rx_pkt_valid === 1'b1);
         got_d = (rx_pkt_drop === 1'b1);
      end
      check({14'h0000, got_v, got_d}, {14'h0000, v, !v});
      check({rx_pkt_hdr, 1'b0, rx_pkt_len}, {h, 1'b0, l});
   endtask
   task automatic chk_data(input logic [7:0] d[$]);
      foreach (d[i]) begin
         rx_rd_addr = 6'(i);
         @(negedge core_clk);
         check({8'h00, rx_rd_data}, {8'h00, d[i]});
      end
   endtask
   task automatic dev_send(input logic pre, input logic [7:0] b[$], input logic bad,
      input logic v, input logic [7:0] h, input logic [6:0] l);
      fork
         begin
            if (pre) spf_dev_model_inst.put_char(8'h55);
            if (pre) spf_dev_model_inst.put_char(FRAME_START_CHAR);
            if (pre) spf_dev_model_inst.put_char(8'h33);
            spf_dev_model_inst.put_pkt(b, bad);
         end
         expect_rx(v, h, l);
      join
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check({12'h000, ser_txd, tx_busy, rx_pkt_valid, rx_pkt_drop}, 16'h0008);
      check({rx_pkt_hdr, 1'b0, rx_pkt_len}, 16'h0000);
   endtask
   task automatic t_link_reset();
      // reflected crc, init zero, low byte first: 0x21 gives 0x308B
      logic [7:0] ex[$] = '{8'h81, 8'h21, 8'h8B, 8'h30, 8'h82};
      logic [7:0] none[$];
      host_send(LINK_RESET_PACKET, 7'h00, none);
      expect_rx(1'b1, 8'h31, 7'h00);
      foreach (ex[i]) check({8'h00, spf_dev_model_inst.raw[i]}, {8'h00, ex[i]});
   endtask
   task automatic t_stuff();
      logic [7:0] d[$] = '{8'h80, 8'h81, 8'h82, 8'h05, 8'h7F};
      logic [7:0] ex[$] = '{8'h80, 8'h00, 8'h80, 8'h01, 8'h80, 8'h02, 8'h05, 8'h7F};
      host_send(INFO_PACKET_SEQ_ZERO, 7'h05, d);
      expect_rx(1'b1, 8'h01, 7'h05);
      foreach (ex[i]) check({8'h00, spf_dev_model_inst.raw[i + 2]}, {8'h00, ex[i]});
      chk_data(d);
   endtask
   task automatic t_max();
      logic [7:0] d[$];
      for (int i = 0; i < 64; i++) d.push_back(8'(i * 3));
      host_send(INFO_PACKET_SEQ_ONE, 7'h46, d);
      expect_rx(1'b1, 8'h11, 7'h40);
      check(16'(spf_dev_model_inst.pkt.size()), 16'h0043);
      chk_data(d);
   endtask
   task automatic t_drops();
      logic [7:0] big[$];
      for (int i = 0; i < 66; i++) big.push_back(8'h01);
      dev_send(1'b0, '{8'h01, 8'h10}, 1'b1, 1'b0, 8'h11, 7'h40);
      dev_send(1'b0, '{8'h05, 8'h10}, 1'b0, 1'b0, 8'h11, 7'h40);
      dev_send(1'b1, '{8'h01, 8'h44}, 1'b0, 1'b1, 8'h01, 7'h01);
      chk_data('{8'h44});
      // header plus 65 data bytes is one byte too long and must be dropped
      dev_send(1'b0, big, 1'b0, 1'b0, 8'h01, 7'h01);
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(negedge core_clk);
      srst = 1'b0;
      t_reset();
      t_link_reset();
      t_stuff();
      t_max();
      t_drops();
      conclude();
   end
   initial begin
      repeat (90000) @(posedge core_clk);
      err_total++;
      conclude();
   end
endmodule // serial_packet_framer_tb
